//--- core/core_mem_test_seq.sv
`timescale 1ns/1ps
`include "core_mem_test_consts.svh"
module core_mem_test_seq
  import core_mem_test_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic start_button_level_i,
  input wire logic step_address_switch_i,
  input wire logic remote_select_i,
  input wire logic manual_select_i,
  input wire logic single_cycle_level_i,
  input wire logic pattern_normal_sel_i,
  input wire logic pattern_worst_sel_i,
  input wire logic stop_final_addr_sel_i,
  input wire logic stop_on_error_sel_i,
  input wire logic count_enable_sel_i,
  input wire logic strobe_pulse_i,
  input wire logic cycle_done_i,
  input wire logic [`INFO_W-1:0] sense_data_i,
  input wire logic [`INFO_W-1:0] pattern_word_i,
  input wire logic [`INFO_W-1:0] manual_info_i,
  input wire logic manual_load_i,
  output logic cycle_timing_trigger_o,
  output logic [1:0] cycle_pulse_counter_o,
  output logic start_memory_ff_o,
  output logic write_cycle_ff_o,
  output logic worst_case_ff_o,
  output logic error_ff_o,
  output logic info_clear_driver_o,
  output logic address_clear_driver_o,
  output logic continue_level_o,
  output logic final_address_detect_o,
  output logic [`ADDR_W-1:0] address_register_o,
  output logic [`INFO_W-1:0] info_register_bits_o
);
  typedef struct packed {
    pulse_count_e pc;
    logic start_ff;
    logic write_ff;
    logic worst_ff;
    logic error_ff;
    logic in_cycle;
    logic trigger;
    logic [`ADDR_W-1:0] addr;
    logic [`INFO_W-1:0] info;
  } seq_s;

  seq_s state_reg;
  seq_s state_next;

  // remote, manual, single and pattern switches are slow panel levels
  logic start_lvl, start_rise, step_rise;
  logic remote_level, manual_level, single_lvl, worst_lvl;
  logic sfa_lvl, soe_lvl, count_lvl, strobe_rise, done_rise;
  logic [`INFO_W-1:0] expect_word;
  logic mismatch, parity_even;
  logic local_start_level, continue_level, final_hit, info_clear;

  panel_sync u_start (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(start_button_level_i), .level_o(start_lvl), .rise_o(start_rise));
  panel_sync u_step (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(step_address_switch_i), .level_o(), .rise_o(step_rise));
  panel_sync u_remote (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(remote_select_i), .level_o(remote_level), .rise_o());
  panel_sync u_manual (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(manual_select_i), .level_o(manual_level), .rise_o());
  panel_sync u_single (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(single_cycle_level_i), .level_o(single_lvl), .rise_o());
  // worst case only when complement chosen and normal not held
  panel_sync u_worst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(pattern_worst_sel_i & ~pattern_normal_sel_i), .level_o(worst_lvl), .rise_o());
  panel_sync u_sfa (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(stop_final_addr_sel_i), .level_o(sfa_lvl), .rise_o());
  panel_sync u_soe (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(stop_on_error_sel_i), .level_o(soe_lvl), .rise_o());
  panel_sync u_count (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(count_enable_sel_i), .level_o(count_lvl), .rise_o());
  // strobe and cycle-done come from the analogue timing chain
  panel_sync u_strobe (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(strobe_pulse_i), .level_o(), .rise_o(strobe_rise));
  panel_sync u_done (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .async_i(cycle_done_i), .level_o(), .rise_o(done_rise));

  pattern_check u_pat (
    .pattern_i(pattern_word_i),
    .complement_i(state_reg.worst_ff),
    .info_i(state_reg.info),
    .expect_o(expect_word),
    .mismatch_o(mismatch),
    .parity_even_o(parity_even)
  );

  assign local_start_level = start_rise & ~remote_level;
  assign final_hit = (state_reg.addr == `FINAL_ADDR);
  assign continue_level = ~remote_level & ~single_lvl
    & ~(sfa_lvl & final_hit & (manual_level | (~state_reg.worst_ff & state_reg.write_ff)))
    & ~(soe_lvl & state_reg.error_ff);
  // lone start press at zero or three, or end-of-cycle continue
  always_comb begin
    info_clear = 1'b0;
    if (!remote_level) begin
      if (local_start_level && (state_reg.pc == pc_zero || state_reg.pc == pc_three)
          && (!manual_level || !state_reg.write_ff)) begin
        info_clear = 1'b1;
      end
      if (done_rise && continue_level && (!manual_level || !state_reg.write_ff)) begin
        info_clear = 1'b1;
      end
    end
  end

  always_comb begin
    logic begin_cycle;
    logic bump_addr;
    begin_cycle = 1'b0;
    bump_addr = 1'b0;
    state_next = state_reg;
    if (clk_en_i) begin
      state_next.trigger = 1'b0;
      if (strobe_rise && state_reg.in_cycle) begin
        if (!state_reg.write_ff) begin
          state_next.info = sense_data_i;
        end else if (!manual_level && !remote_level) begin
          state_next.info = expect_word;
        end else if (parity_even) begin
          state_next.info[`INFO_W-1] = 1'b1;
        end
      end
      if (manual_load_i && !state_reg.in_cycle && state_reg.pc == pc_zero) begin
        state_next.info = manual_info_i;
      end
      if (done_rise && state_reg.in_cycle) begin
        state_next.in_cycle = 1'b0;
        if (manual_level && state_reg.write_ff) begin
          state_next.info[`INFO_W-1] = 1'b0;
        end
      end
      unique case (state_reg.pc)
        pc_zero: begin
          if (local_start_level) begin
            begin_cycle = 1'b1;
          end
        end
        pc_one: begin
          state_next.pc = pc_two;
        end
        pc_two: begin
          if (state_reg.write_ff == 1'b0 && state_reg.in_cycle == 1'b0) begin
            if ((parity_even && manual_level) || (!manual_level && mismatch)) begin
              state_next.error_ff = 1'b1;
            end
          end
          if (!state_reg.in_cycle) begin
            state_next.pc = pc_three;
          end
        end
        pc_three: begin
          if (remote_level || single_lvl) begin
            state_next.pc = pc_zero;
            state_next.start_ff = 1'b1;
          end else if (state_reg.start_ff) begin
            begin_cycle = 1'b1;
          end else if (local_start_level || continue_level) begin
            state_next.start_ff = 1'b1;
          end
        end
      endcase
      if (begin_cycle) begin
        state_next.pc = pc_one;
        state_next.trigger = 1'b1;
        state_next.in_cycle = 1'b1;
        state_next.start_ff = 1'b0;
        if (state_reg.start_ff) begin
          bump_addr = count_lvl & ~state_reg.worst_ff & (manual_level | state_reg.write_ff);
          if (!manual_level) begin
            state_next.write_ff = ~state_reg.write_ff;
            if (!state_reg.write_ff && worst_lvl) begin
              state_next.worst_ff = ~state_reg.worst_ff;
            end
          end
        end
      end
      if (step_rise && !remote_level) begin
        bump_addr = 1'b1;
      end
      if (bump_addr) begin
        state_next.addr = state_reg.addr + `ADDR_W'(1);
      end
      if (info_clear) begin
        state_next.info = '0;
        state_next.error_ff = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cycle_timing_trigger_o = state_reg.trigger;
  assign cycle_pulse_counter_o = state_reg.pc;
  assign start_memory_ff_o = state_reg.start_ff;
  assign write_cycle_ff_o = state_reg.write_ff;
  assign worst_case_ff_o = state_reg.worst_ff;
  assign error_ff_o = state_reg.error_ff;
  assign info_clear_driver_o = info_clear;
  // gated by the remote level, so it stays low in local
  assign address_clear_driver_o = remote_level & done_rise;
  assign continue_level_o = continue_level;
  assign final_address_detect_o = final_hit;
  assign address_register_o = state_reg.addr;
  assign info_register_bits_o = state_reg.info;

  property p_start_trigger;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_zero && local_start_level) |=> (state_reg.trigger && state_reg.pc == pc_one);
  endproperty
  a_start_trigger: assert property (p_start_trigger) else $error("start did not trigger cycle");

  property p_one_to_two;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_one) |=> state_reg.pc == pc_two;
  endproperty
  a_one_to_two: assert property (p_one_to_two) else $error("counter did not advance from one");

  property p_single_zero;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_three && single_lvl) |=> (state_reg.pc == pc_zero && state_reg.start_ff);
  endproperty
  a_single_zero: assert property (p_single_zero) else $error("single cycle not parked at zero");

  property p_stop_holds;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_three && !state_reg.start_ff && !continue_level && !local_start_level
       && !single_lvl && !remote_level) |=> state_reg.pc == pc_three;
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped run left count three");

  property p_restart;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_three && state_reg.start_ff && !single_lvl && !remote_level)
      |=> (state_reg.pc == pc_one && !state_reg.start_ff && state_reg.trigger);
  endproperty
  a_restart: assert property (p_restart) else $error("second clock at three did not restart");

  property p_addr_clear_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !remote_level |-> !address_clear_driver_o;
  endproperty
  a_addr_clear_off: assert property (p_addr_clear_off) else $error("address clear driven");

  property p_clear_effect;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && info_clear) |=> (state_reg.info == '0 && !state_reg.error_ff);
  endproperty
  a_clear_effect: assert property (p_clear_effect) else $error("clear driver left data");

  property p_step;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && step_rise && !remote_level) |=> state_reg.addr == $past(state_reg.addr) + `ADDR_W'(1);
  endproperty
  a_step: assert property (p_step) else $error("step did not increment address");

  property p_no_remote_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && remote_level && state_reg.pc == pc_zero) |=> !state_reg.trigger;
  endproperty
  a_no_remote_start: assert property (p_no_remote_start) else $error("start level in remote");

  property p_trigger_pulse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.trigger) |=> !state_reg.trigger;
  endproperty
  a_trigger_pulse: assert property (p_trigger_pulse) else $error("trigger longer than one clock");

  property p_two_to_three;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_two && !state_reg.in_cycle) |=> state_reg.pc == pc_three;
  endproperty
  a_two_to_three: assert property (p_two_to_three) else $error("counter did not reach three");

  property p_parity_error;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_two && !state_reg.in_cycle && !state_reg.write_ff && manual_level
       && parity_even && !info_clear) |=> state_reg.error_ff;
  endproperty
  a_parity_error: assert property (p_parity_error) else $error("parity error not flagged");

  property p_pattern_error;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_two && !state_reg.in_cycle && !state_reg.write_ff && !manual_level
       && mismatch && !info_clear) |=> state_reg.error_ff;
  endproperty
  a_pattern_error: assert property (p_pattern_error) else $error("pattern mismatch not flagged");

  property p_auto_write_load;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && strobe_rise && state_reg.in_cycle && state_reg.write_ff && !manual_level && !remote_level
       && !info_clear) |=> state_reg.info == $past(expect_word);
  endproperty
  a_auto_write_load: assert property (p_auto_write_load) else $error("pattern word not loaded");

  property p_parity_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && strobe_rise && state_reg.in_cycle && state_reg.write_ff && manual_level && parity_even
       && !done_rise && !info_clear) |=> state_reg.info[`INFO_W-1];
  endproperty
  a_parity_set: assert property (p_parity_set) else $error("parity bit not set");

  property p_parity_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && done_rise && state_reg.in_cycle && manual_level && state_reg.write_ff)
      |=> !state_reg.info[`INFO_W-1];
  endproperty
  a_parity_clear: assert property (p_parity_clear) else $error("parity bit not cleared");

  property p_manual_keep;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && done_rise && manual_level && state_reg.write_ff) |-> !info_clear;
  endproperty
  a_manual_keep: assert property (p_manual_keep) else $error("manual write cleared register");

  property p_auto_toggle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_zero && local_start_level && state_reg.start_ff && !manual_level)
      |=> state_reg.write_ff != $past(state_reg.write_ff);
  endproperty
  a_auto_toggle: assert property (p_auto_toggle) else $error("write flag did not alternate");

  property p_worst_no_bump;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.worst_ff && !step_rise) |=> $stable(state_reg.addr);
  endproperty
  a_worst_no_bump: assert property (p_worst_no_bump) else $error("address moved in worst case");

  property p_count_inhibit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && !count_lvl && !step_rise) |=> $stable(state_reg.addr);
  endproperty
  a_count_inhibit: assert property (p_count_inhibit) else $error("address counted while inhibited");

  property p_continue_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg.pc == pc_three && !state_reg.start_ff && continue_level && !remote_level
       && !single_lvl) |=> (state_reg.start_ff && state_reg.pc == pc_three);
  endproperty
  a_continue_start: assert property (p_continue_start) else $error("first clock at three missed");
endmodule

//--- include/core_mem_test_consts.svh
`ifndef CORE_MEM_TEST_CONSTS_SVH
`define CORE_MEM_TEST_CONSTS_SVH
// What this block does
// - halt when address reaches octal 7777
// - continuous stop at three, single at zero
// - local auto write loads pattern word
// - manual write sets bit 48 on even parity
// - manual write end clears parity bit
// - clear driver only when continuing, auto or read
// - clear driver clears info register and error
// - address clear driver inhibited in local
// - start level only in local mode
// - start at zero triggers cycle, counter one
// - next start after manual write increments address
// - read parity error sets error at pulse two
// - continuous: two clocks at three, then restart
// - normal auto: read then write per address
// - auto read compares pattern, ignores parity
// - worst case: four cycles with complement
// - step switch increments address in local
// - start at zero clears info on read or auto
// - auto start toggles write flip-flop
// - start flip-flop records single-cycle halt
// - all actions sequenced by one system clock
// - continue only local, continuous, no stop condition
// - remote or single returns counter to zero
// - address count gated by count, flag, mode
`define ADDR_W 12
`define INFO_W 49
`define FINAL_ADDR 12'o7777
`define PC_ZERO 2'h0
`define PC_ONE 2'h1
`define PC_TWO 2'h2
`define PC_THREE 2'h3
`endif

//--- include/core_mem_test_pkg.sv
package core_mem_test_pkg;
  typedef enum logic [1:0] {
    pc_zero = 2'b00,
    pc_one = 2'b01,
    pc_two = 2'b10,
    pc_three = 2'b11
  } pulse_count_e;
endpackage

//--- core/panel_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser with rising-edge pulse
module panel_sync (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;
  sync_s state_reg;
  sync_s state_next;
  always_comb begin
    state_next = state_reg;
    if (clk_en_i) begin
      state_next.meta = async_i;
      state_next.sync = state_reg.meta;
      state_next.prev = state_reg.sync;
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign level_o = state_reg.sync;
  assign rise_o = clk_en_i & state_reg.sync & ~state_reg.prev;
endmodule

//--- core/pattern_check.sv
`timescale 1ns/1ps
`include "core_mem_test_consts.svh"
// pattern word, optionally complemented, and parity of the info register
module pattern_check (
  input wire logic [`INFO_W-1:0] pattern_i,
  input wire logic complement_i,
  input wire logic [`INFO_W-1:0] info_i,
  output logic [`INFO_W-1:0] expect_o,
  output logic mismatch_o,
  output logic parity_even_o
);
  assign expect_o = complement_i ? ~pattern_i : pattern_i;
  assign mismatch_o = (info_i != expect_o);
  assign parity_even_o = ~(^info_i);
endmodule

//--- tb/chain_model.sv
`timescale 1ns/1ps
`include "core_mem_test_consts.svh"
// core stack timing chain stand-in; words never written read back as zero
module chain_model #(
  parameter int STB_DLY = 3,
  parameter int DONE_DLY = 4
) (
  input wire logic core_clk_i,
  input wire logic trig_i,
  input wire logic write_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`INFO_W-1:0] info_i,
  output logic strobe_o,
  output logic done_o,
  output logic [`INFO_W-1:0] sense_o
);
  logic [`INFO_W-1:0] mem [int];
  logic [`INFO_W-1:0] word;
  logic wr;
  int a;
  initial begin
    strobe_o = 1'b0;
    done_o = 1'b0;
    sense_o = '1;
    forever begin
      @(negedge core_clk_i);
      if (trig_i === 1'b1) begin
        a = int'(addr_i);
        wr = write_i;
        word = mem.exists(a) ? mem[a] : '0;
        repeat (STB_DLY) @(negedge core_clk_i);
        sense_o = word;
        strobe_o = 1'b1;
        repeat (2) @(negedge core_clk_i);
        strobe_o = 1'b0;
        // word held until the synchronised strobe has latched it
        repeat (DONE_DLY) @(negedge core_clk_i);
        // sense amps float afterwards: show the inverse, not a stale word
        sense_o = ~word;
        if (wr) mem[a] = info_i;
        done_o = 1'b1;
        repeat (2) @(negedge core_clk_i);
        done_o = 1'b0;
      end
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`include "core_mem_test_consts.svh"
module tb;
  import core_mem_test_pkg::*;
  logic core_clk_i, reset_n_i, start, step, remote, manual, single, normal, worst;
  logic stop_fa, stop_err, count, load, strobe, done;
  logic trig, start_ff, write_ff, worst_ff, error_ff, clr_drv, addr_clr, cont, final_det;
  logic [1:0] pc;
  logic [`ADDR_W-1:0] addr, ea;
  logic [`INFO_W-1:0] sense, info, minfo;
  logic [`INFO_W-1:0] pat = 49'h0000_0F0F_1234;
  logic ew, ec, clr_seen;
  int n_errors, checks, i;

  core_mem_test_seq DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .start_button_level_i(start), .step_address_switch_i(step), .remote_select_i(remote),
    .manual_select_i(manual), .single_cycle_level_i(single), .pattern_normal_sel_i(normal),
    .pattern_worst_sel_i(worst), .stop_final_addr_sel_i(stop_fa), .stop_on_error_sel_i(stop_err),
    .count_enable_sel_i(count), .strobe_pulse_i(strobe), .cycle_done_i(done),
    .sense_data_i(sense), .pattern_word_i(pat), .manual_info_i(minfo), .manual_load_i(load),
    .cycle_timing_trigger_o(trig), .cycle_pulse_counter_o(pc), .start_memory_ff_o(start_ff),
    .write_cycle_ff_o(write_ff), .worst_case_ff_o(worst_ff), .error_ff_o(error_ff),
    .info_clear_driver_o(clr_drv), .address_clear_driver_o(addr_clr), .continue_level_o(cont),
    .final_address_detect_o(final_det), .address_register_o(addr), .info_register_bits_o(info)
  );

  chain_model chain (
    .core_clk_i(core_clk_i), .trig_i(trig), .write_i(write_ff), .addr_i(addr), .info_i(info),
    .strobe_o(strobe), .done_o(done), .sense_o(sense)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string what, input logic [`INFO_W-1:0] seen, input logic [`INFO_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_pc(input logic [1:0] want, input int lim);
    int j;
    for (j = 0; j < lim && pc !== want; j++) @(negedge core_clk_i);
    if (pc !== want) begin
      n_errors++;
      $display("ERROR counter expected %0d seen %0d", want, pc);
      wrap_up();
    end
  endtask

  // hold the press until the cycle starts, so one press gives one cycle
  task automatic go;
    int j;
    start = 1'b1;
    clr_seen = 1'b0;
    for (j = 0; j < 12 && trig !== 1'b1; j++) begin
      clr_seen |= clr_drv;
      @(negedge core_clk_i);
    end
    start = 1'b0;
    chk("trigger", trig, 1);
    chk("counter", pc, 1);
    if (trig !== 1'b1) wrap_up();
  endtask

  task automatic run(input logic [1:0] want);
    go();
    wait_pc(want, 60);
    repeat (2) @(negedge core_clk_i);
  endtask

  task automatic press_step;
    step = 1'b1;
    repeat (5) @(negedge core_clk_i);
    step = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask

  initial begin
    {start, step, remote, manual, single, normal, worst, stop_fa, stop_err, count, load} = '0;
    n_errors = 0;
    checks = 0;
    minfo = '0;
    reset_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    @(negedge core_clk_i);
    chk("counter", pc, 0);
    chk("address", addr, 0);
    // remote: neither panel button acts
    remote = 1'b1;
    start = 1'b1;
    press_step();
    start = 1'b0;
    chk("remote start", pc, 0);
    chk("remote step", addr, 0);
    chk("addr clear", addr_clr, 0);
    remote = 1'b0;
    press_step();
    chk("step", addr, 1);
    $display("test panel done");
    // auto normal single cycles: read, write, read, write
    {single, count, normal} = 3'b111;
    run(0);
    chk("halt counter", pc, 0);
    chk("halt start ff", start_ff, 1);
    chk("read mismatch", error_ff, 1);
    chk("clear on auto start", clr_seen, 1);
    run(0);
    chk("error cleared", error_ff, 0);
    chk("write ff", write_ff, 1);
    chk("no bump on read", addr, 1);
    chk("pattern stored", chain.mem[1], pat);
    run(0);
    chk("bump after write", addr, 2);
    chk("write ff", write_ff, 0);
    run(0);
    $display("test auto done");
    // manual write keeps the register and regenerates parity
    manual = 1'b1;
    minfo = 49'h0_0000_0000_0003;
    load = 1'b1;
    @(negedge core_clk_i);
    load = 1'b0;
    run(0);
    chk("manual bump", addr, 3);
    chk("parity set", chain.mem[3], 49'h1_0000_0000_0003);
    chk("kept info", info, minfo);
    chk("no clear on manual write", clr_seen, 0);
    manual = 1'b0;
    run(0);
    manual = 1'b1;
    run(0);
    chk("parity error", error_ff, 1);
    chk("clear on manual read", clr_seen, 1);
    chk("address", addr, 5);
    $display("test manual done");
    // continuous: stop on error, then run to the final address
    single = 1'b0;
    stop_err = 1'b1;
    run(3);
    chk("error stop", pc, 3);
    chk("no continue", cont, 0);
    chk("address", addr, 6);
    stop_err = 1'b0;
    stop_fa = 1'b1;
    go();
    wait_pc(3, 60);
    @(negedge core_clk_i);
    chk("first clock", start_ff, 1);
    chk("still three", pc, 3);
    @(negedge core_clk_i);
    chk("restart", trig, 1);
    chk("counter", pc, 1);
    chk("address", addr, 8);
    for (i = 0; i < 80000 && !(pc === 2'd3 && final_det === 1'b1); i++) @(negedge core_clk_i);
    chk("final reached", final_det, 1);
    if (final_det !== 1'b1) wrap_up();
    repeat (4) @(negedge core_clk_i);
    chk("final stop", pc, 3);
    chk("final address", addr, 12'hFFF);
    chk("final detect", final_det, 1);
    chk("no continue", cont, 0);
    $display("test continuous done");
    // worst case four cycle sequence from a fresh reset
    reset_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    {manual, single, stop_fa, normal, worst} = 5'b01001;
    run(0);
    ew = 1'b0;
    ec = 1'b0;
    ea = '0;
    for (i = 0; i < 4; i++) begin
      ea += (!ec && ew);
      ec ^= !ew;
      ew = !ew;
      run(0);
      chk("write ff", write_ff, ew);
      chk("worst ff", worst_ff, ec);
      chk("address", addr, ea);
      if (ew)
        chk("stored", chain.mem[int'(addr)], ec ? ~pat : pat);
      else
        chk("compare", error_ff, 0);
    end
    $display("test worst case done");
    wrap_up();
  end
endmodule
